/* File: src/flash_host_pkg.sv */
// Purpose: Constants shared by the sector flash programming controller
// Assumes: 250 MHz system clock, byte-wide parallel flash outside
// Notes: Command bytes and addresses are parameters of plain value

package flash_host_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ = 250;                 // System clock rate
  localparam int CLK_PERIOD_NS = 4;             // Period in ns
  localparam int WRITE_PULSE_NS = 200;          // Least write pulse low
  localparam int WRITE_HIGH_NS = 200;           // Least write pulse high
  localparam int SETUP_NS = 100;                // Address and data set-up
  localparam int HOLD_NS = 100;                 // Address hold after strobe
  localparam int READ_ACCESS_NS = 150;          // Slowest read access
  localparam int DRIVE_HIGH_PULSE_NS = 150;     // Output-enable high between polls
  localparam int BYTE_LOAD_WINDOW_US = 150;     // Longest gap between byte loads
  localparam int SECTOR_PROGRAM_TIME_MS = 20;   // Longest internal program cycle

  // Least times round up, longest round down
  localparam int WP_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SU_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AH_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OEHP_CYC = (DRIVE_HIGH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLW_CYC = BYTE_LOAD_WINDOW_US * CLK_MHZ;
  localparam int SPT_CYC = SECTOR_PROGRAM_TIME_MS * 1000 * CLK_MHZ;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int ADDR_W = 17;                   // Address lines
  localparam int DATA_W = 8;                    // Data lines
  localparam int SECTOR_BYTES = 128;            // Bytes per sector
  localparam int SECTOR_LSB = 7;                // Lowest sector address line
  localparam int TOGGLE_BIT = 6;                // Toggle status bit position
  localparam int CMD_ADDR_W = 15;               // Command address lines

  // ****************************************
  // Command codes, plain values
  // ****************************************
  localparam logic [14:0] CMD_ADDR_A = 15'h5555; // First unlock address
  localparam logic [14:0] CMD_ADDR_B = 15'h2aaa; // Second unlock address
  localparam logic [7:0] CMD_DATA_A = 8'haa;    // First unlock byte
  localparam logic [7:0] CMD_DATA_B = 8'h55;    // Second unlock byte
  localparam logic [7:0] CMD_PROG = 8'ha0;      // Program unlock
  localparam logic [7:0] CMD_ID_ENTER = 8'h90;  // Identification entry
  localparam logic [7:0] CMD_ID_EXIT = 8'hf0;   // Identification exit
  localparam logic [7:0] CMD_LOCK = 8'h80;      // Lockout prefix
  localparam logic [7:0] CMD_LOCK_LO = 8'h40;   // Lock lower boot block
  localparam logic [7:0] CMD_LOCK_HI = 8'h41;   // Lock upper boot block

  // Operation codes on the user port
  localparam logic [2:0] OP_READ = 3'h0;        // Plain array read
  localparam logic [2:0] OP_PROG = 3'h1;        // Program sector from FIFO
  localparam logic [2:0] OP_ID_ENTER = 3'h2;    // Enter identification mode
  localparam logic [2:0] OP_ID_EXIT = 3'h3;     // Leave identification mode
  localparam logic [2:0] OP_LOCK_LO = 3'h4;     // Lock lower boot block
  localparam logic [2:0] OP_LOCK_HI = 3'h5;     // Lock upper boot block

endpackage : flash_host_pkg

/* File: src/flash_host.sv */
// Purpose: Host controller driving a sector-programmed parallel flash
// Assumes: Flash strobes are active low, data pins are two-way
// Notes: Program data streams through a FIFO, 128 bytes per sector
//
// Summary of operation
// R1: Output enable held high while writing
// R2: Same sector address on every byte load
// R3: Unloaded bytes end undefined; always load all
// R4: Unlock sequence sent before every program
// R5: Full sector loaded before program starts
// R6: Next byte load inside the load window
// R7: Each poll read strobes output enable afresh
// R8: Only compare successive toggle bits
// R9: Poll address held constant
// R10: Identification reads at address zero or one
// R11: Identification mode lost at power-off
// R12: Exit sequence restores array reads
// R13: Lockout sequence variant picks boot block
// R14: Command bytes at fifteen-bit addresses
// R15: Program cycle bounded by program time
// R16: Poll until toggle bit stops changing
`timescale 1ns/1ps

// ****************************************
// FIFO
// ****************************************
module host_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];                // Storage
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;               // Fill level
  logic push, pop;

  // Handshakes and pointer updates
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  assign in_ready = (count != (AW+1)'(DEPTH));  // Honest full
  assign out_valid = (count != '0);             // Honest empty
  assign out_data = mem[rd_ptr];

  // Register state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage write, no reset needed
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : host_fifo

// ****************************************
// Controller
// ****************************************
module flash_host #(
  parameter int BLW_CYCLES = flash_host_pkg::BLW_CYC,   // Byte load window
  parameter int SPT_CYCLES = flash_host_pkg::SPT_CYC,   // Program time limit
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [2:0] op_code,
  input wire logic [16:0] op_addr,
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic op_error,
  output logic [16:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [7:0] flash_dq_in
);
  typedef enum logic [9:0] {
    IDLE = 10'h001, CMD = 10'h002, WSET = 10'h004, WLOW = 10'h008, WHIGH = 10'h010,
    RLOW = 10'h020, RHIGH = 10'h040, POLL = 10'h080, DONE = 10'h100, LOAD = 10'h200
  } state_e;

  state_e state, next_state;
  logic [2:0] op, next_op;                      // Current operation
  logic [2:0] step, next_step;                  // Command byte index
  logic [7:0] nbytes, next_nbytes;              // Bytes loaded
  logic [31:0] cnt, next_cnt;                   // Phase counter
  logic [31:0] tmo, next_tmo;                   // Program time counter
  logic [16:0] addr, next_addr;
  logic [16:0] base, next_base;                 // Operation address, kept through commands
  logic ce_n, next_ce_n, oe_n, next_oe_n, we_n, next_we_n, dq_oe_n, next_dq_oe_n;
  logic [7:0] dout, next_dout;
  logic [7:0] rdat, next_rdat;
  logic rv, next_rv, err, next_err, prev_tog, next_prev_tog, first, next_first;
  logic [7:0] dq_s1, dq_s2;                     // Input synchroniser
  logic [7:0] f_data;
  logic f_valid, f_pop;

  host_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk), .nrst(nrst), .in_data(wr_data), .in_valid(wr_valid),
    .in_ready(wr_ready), .out_data(f_data), .out_valid(f_valid), .out_ready(f_pop)
  );

  // Command byte table per operation and step
  function automatic logic [22:0] cmd_byte(input logic [2:0] o, input logic [2:0] s);
    logic [7:0] last;
    last = (o == flash_host_pkg::OP_PROG) ? flash_host_pkg::CMD_PROG :
           (o == flash_host_pkg::OP_ID_ENTER) ? flash_host_pkg::CMD_ID_ENTER :
           (o == flash_host_pkg::OP_ID_EXIT) ? flash_host_pkg::CMD_ID_EXIT :
           flash_host_pkg::CMD_LOCK;
    case (s)
      3'h0, 3'h3: cmd_byte = {flash_host_pkg::CMD_ADDR_A, flash_host_pkg::CMD_DATA_A};
      3'h1, 3'h4: cmd_byte = {flash_host_pkg::CMD_ADDR_B, flash_host_pkg::CMD_DATA_B};
      3'h2: cmd_byte = {flash_host_pkg::CMD_ADDR_A, last};
      default: cmd_byte = {flash_host_pkg::CMD_ADDR_A,
        (o == flash_host_pkg::OP_LOCK_HI) ? flash_host_pkg::CMD_LOCK_HI
                                          : flash_host_pkg::CMD_LOCK_LO};
    endcase
  endfunction : cmd_byte

  // Command length: lockout six bytes, others three
  function automatic logic [2:0] cmd_len(input logic [2:0] o);
    cmd_len = (o == flash_host_pkg::OP_LOCK_LO || o == flash_host_pkg::OP_LOCK_HI)
              ? 3'h6 : 3'h3;
  endfunction : cmd_len

  // Two-stage synchroniser for data pins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end else begin
      dq_s1 <= flash_dq_in;
      dq_s2 <= dq_s1;
    end
  end

  assign f_pop = (state == LOAD) && f_valid && (nbytes != 8'(flash_host_pkg::SECTOR_BYTES));

  // Sequencer next state
  always_comb begin
    logic [22:0] cb;
    cb = cmd_byte(op, step);
    next_state = state;
    next_op = op;
    next_step = step;
    next_nbytes = nbytes;
    next_cnt = cnt;
    next_tmo = tmo;
    next_addr = addr;
    next_base = base;
    next_ce_n = ce_n;
    next_oe_n = oe_n;
    next_we_n = we_n;
    next_dq_oe_n = dq_oe_n;
    next_dout = dout;
    next_rdat = rdat;
    next_rv = 1'b0;
    next_err = err;
    next_prev_tog = prev_tog;
    next_first = first;
    case (state)
      IDLE: begin
        if (op_valid) begin
          next_op = op_code;
          next_addr = op_addr;
          next_base = op_addr;                  // Command bytes overwrite addr
          next_step = 3'h0;
          next_nbytes = 8'h00;
          next_err = 1'b0;
          // Reads go straight out; others send a command first
          next_state = (op_code == flash_host_pkg::OP_READ) ? RLOW : CMD; // R14
          next_cnt = 32'h0;
          if (op_code == flash_host_pkg::OP_READ) begin
            next_ce_n = 1'b0;
            next_oe_n = 1'b0;
            next_dq_oe_n = 1'b1;
          end
        end
      end
      CMD: begin
        // Present a command byte at its fifteen-bit address
        next_addr = {2'b00, cb[22:8]};          // R14
        next_dout = cb[7:0];                    // R14 R4 R13
        next_oe_n = 1'b1;                       // R1
        next_dq_oe_n = 1'b0;
        next_cnt = 32'h0;
        next_state = WSET;
      end
      LOAD: begin
        // Stream one sector, same sector bits on every byte
        if (f_pop) begin
          next_addr = {base[16:flash_host_pkg::SECTOR_LSB], 7'(nbytes)}; // R2
          next_dout = f_data;
          next_oe_n = 1'b1;                     // R1
          next_dq_oe_n = 1'b0;
          next_nbytes = nbytes + 8'h01;
          next_cnt = 32'h0;
          next_state = WSET;
        end else if (cnt >= 32'(BLW_CYCLES - 1)) begin
          next_err = 1'b1;                      // R6
          next_state = DONE;
        end else begin
          next_cnt = cnt + 32'h1;
        end
      end
      WSET: begin
        // Address and data set-up before the strobe falls
        next_cnt = cnt + 32'h1;
        if (cnt >= 32'(flash_host_pkg::SU_CYC - 1)) begin
          next_ce_n = 1'b0;
          next_we_n = 1'b0;
          next_cnt = 32'h0;
          next_state = WLOW;
        end
      end
      WLOW: begin
        next_cnt = cnt + 32'h1;
        if (cnt >= 32'(flash_host_pkg::WP_CYC - 1)) begin
          next_ce_n = 1'b1;
          next_we_n = 1'b1;
          next_cnt = 32'h0;
          next_state = WHIGH;
        end
      end
      WHIGH: begin
        // Hold and recovery, then choose what follows
        next_cnt = cnt + 32'h1;
        if (cnt >= 32'(flash_host_pkg::WPH_CYC - 1)) begin
          next_cnt = 32'h0;
          next_dq_oe_n = 1'b1;
          if (step != 3'h7 && step + 3'h1 < cmd_len(op)) begin
            next_step = step + 3'h1;
            next_state = CMD;
          end else if (op == flash_host_pkg::OP_PROG &&
                       nbytes != 8'(flash_host_pkg::SECTOR_BYTES)) begin
            next_step = 3'h7;
            next_state = LOAD;                  // R5 R3
          end else if (op == flash_host_pkg::OP_PROG) begin
            next_tmo = 32'h0;
            next_first = 1'b1;
            next_addr = op_addr_hold(addr);     // R9
            next_state = RHIGH;
          end else begin
            next_state = DONE;                  // R12 R11
          end
        end
      end
      RLOW: begin
        // Read strobe held for access time
        next_cnt = cnt + 32'h1;
        if (op == flash_host_pkg::OP_PROG) begin
          next_tmo = tmo + 32'h1;
        end
        if (cnt >= 32'(flash_host_pkg::RD_CYC + 1)) begin
          next_ce_n = 1'b1;
          next_oe_n = 1'b1;                     // R7
          next_cnt = 32'h0;
          if (op == flash_host_pkg::OP_PROG) begin
            next_prev_tog = dq_s2[flash_host_pkg::TOGGLE_BIT];
            next_first = 1'b0;
            // Finished once two reads agree
            next_state = (!first && dq_s2[flash_host_pkg::TOGGLE_BIT] == prev_tog)
                         ? DONE : RHIGH;        // R8 R16
          end else begin
            next_rdat = dq_s2;                  // R10
            next_rv = 1'b1;
            next_state = DONE;
          end
        end
      end
      RHIGH: begin
        // Output enable high between polls
        next_cnt = cnt + 32'h1;
        next_tmo = tmo + 32'h1;
        if (tmo >= 32'(SPT_CYCLES - 1)) begin
          next_err = 1'b1;                      // R15
          next_state = DONE;
        end else if (cnt >= 32'(flash_host_pkg::OEHP_CYC - 1)) begin
          next_ce_n = 1'b0;
          next_oe_n = 1'b0;
          next_cnt = 32'h0;
          next_state = RLOW;                    // R7
        end
      end
      DONE: begin
        next_ce_n = 1'b1;
        next_oe_n = 1'b1;
        next_we_n = 1'b1;
        next_dq_oe_n = 1'b1;
        next_state = IDLE;
      end
      default: next_state = IDLE;
    endcase
  end

  // Poll address: first byte of the sector, kept fixed
  function automatic logic [16:0] op_addr_hold(input logic [16:0] a);
    op_addr_hold = {a[16:flash_host_pkg::SECTOR_LSB], 7'h00};
  endfunction : op_addr_hold

  // Register sequencer state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= IDLE;
      op <= 3'h0;
      step <= 3'h0;
      nbytes <= 8'h00;
      cnt <= 32'h0;
      tmo <= 32'h0;
      addr <= 17'h00000;
      base <= 17'h00000;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      dq_oe_n <= 1'b1;
      dout <= 8'h00;
      rdat <= 8'h00;
      rv <= 1'b0;
      err <= 1'b0;
      prev_tog <= 1'b0;
      first <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      step <= next_step;
      nbytes <= next_nbytes;
      cnt <= next_cnt;
      tmo <= next_tmo;
      addr <= next_addr;
      base <= next_base;
      ce_n <= next_ce_n;
      oe_n <= next_oe_n;
      we_n <= next_we_n;
      dq_oe_n <= next_dq_oe_n;
      dout <= next_dout;
      rdat <= next_rdat;
      rv <= next_rv;
      err <= next_err;
      prev_tog <= next_prev_tog;
      first <= next_first;
    end
  end

  assign op_ready = (state == IDLE);
  assign flash_addr = addr;
  assign flash_ce_n = ce_n;
  assign flash_oe_n = oe_n;
  assign flash_we_n = we_n;
  assign flash_dq_out = dout;
  assign flash_dq_oe_n = dq_oe_n;
  assign rd_data = rdat;
  assign rd_valid = rv;
  assign op_error = err;

  // ****************************************
  // Assertions
  // ****************************************
  property p_oe_high_in_write;
    @(posedge sys_clk) disable iff (!nrst) (!flash_we_n && !flash_ce_n) |-> flash_oe_n;
  endproperty
  a_oe_high_in_write: assert property (p_oe_high_in_write) // R1
    else $error("output enable low during write");

  property p_sector_stable;
    @(posedge sys_clk) disable iff (!nrst)
      (state == WLOW && op == flash_host_pkg::OP_PROG && step == 3'h7)
      |-> flash_addr[16:flash_host_pkg::SECTOR_LSB] == base[16:flash_host_pkg::SECTOR_LSB];
  endproperty
  a_sector_stable: assert property (p_sector_stable) // R2
    else $error("sector address moved during load");

  property p_full_sector;
    @(posedge sys_clk) disable iff (!nrst)
      (state == WHIGH && $past(state) == WLOW && op == flash_host_pkg::OP_PROG && step == 3'h7)
      |-> nbytes <= 8'd128;
  endproperty
  a_full_sector: assert property (p_full_sector) // R5
    else $error("more bytes than a sector");

  property p_poll_only_full;
    @(posedge sys_clk) disable iff (!nrst)
      (state == RHIGH && $past(state) == WHIGH) |-> nbytes == 8'd128;
  endproperty
  a_poll_only_full: assert property (p_poll_only_full) // R3
    else $error("program started with partial sector");

  property p_write_pulse;
    @(posedge sys_clk) disable iff (!nrst)
      $fell(flash_we_n) |-> (!flash_we_n)[*8];
  endproperty
  a_write_pulse: assert property (p_write_pulse) // Write pulse low at least 8 cycles
    else $error("write pulse too short");

  property p_poll_addr;
    @(posedge sys_clk) disable iff (!nrst)
      (state == RLOW && op == flash_host_pkg::OP_PROG) |-> $stable(flash_addr);
  endproperty
  a_poll_addr: assert property (p_poll_addr) // R9
    else $error("poll address changed");

  property p_oe_high_pulse;
    @(posedge sys_clk) disable iff (!nrst)
      ($rose(flash_oe_n) && state == RHIGH) |-> flash_oe_n[*8];
  endproperty
  a_oe_high_pulse: assert property (p_oe_high_pulse) // R7
    else $error("output enable high pulse too short");

  property p_load_window;
    @(posedge sys_clk) disable iff (!nrst)
      (state == LOAD) |-> cnt < 32'(BLW_CYCLES);
  endproperty
  a_load_window: assert property (p_load_window) // R6
    else $error("byte load window overrun");

  property p_prog_time;
    @(posedge sys_clk) disable iff (!nrst)
      (state == RHIGH) |-> tmo < 32'(SPT_CYCLES) + 32'h40;
  endproperty
  a_prog_time: assert property (p_prog_time) // R15
    else $error("program cycle not bounded");

endmodule : flash_host

/* File: verif/flash_model.sv */
// Purpose: Behavioural byte-wide sector flash seen by the host controller
// Assumes: Strobes active low, a write is taken on the rising strobe
// Notes: Bus faults of the host are counted in viol
`timescale 1ns/1ps

// ****************************************
// Flash model
// ****************************************
module flash_model #(
  parameter int PROG_NS = 4000,         // Internal program time
  parameter logic [7:0] MAKER = 8'h3c,  // Arbitrary value
  parameter logic [7:0] PART = 8'hc3    // Arbitrary value
) (
  input wire logic [16:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] dq_w,
  input wire logic dq_oe_n,
  output logic [7:0] dq_r,
  output logic busy,
  output logic [1:0] lock,
  output int viol
);
  logic [7:0] mem [0:131071];  // Array contents
  logic [7:0] buf_d [0:127];   // Sector load latches
  logic [127:0] got;           // Loaded offsets
  logic [14:0] a0, a1, a2;     // Last write addresses
  logic [7:0] d0, d1, d2;      // Last write bytes
  logic [16:0] paddr;          // Poll address
  logic [9:0] sec;             // Sector being loaded
  logic loading, idm, lpend, tog, blk;
  logic wseen;                 // A real write strobe has fallen
  logic [7:0] rdv, last;
  int nload, npoll;
  wire wstb = ce_n | we_n;     // Write strobe
  wire rsel = ce_n | oe_n;     // Read strobe

  initial begin
    for (int i = 0; i < 131072; i++) mem[i] = i[7:0] ^ i[15:8];
    {busy, lock, viol, loading, idm, lpend, tog, last, blk, wseen} = '0;
    {a0, a1, a2, d0, d1, d2, npoll, nload, got} = '0;
  end

  // Status while busy, codes in identification mode
  always_comb begin
    if (busy) rdv = {~d0[7], tog, 6'h00};
    else if (idm && addr[16:1] == 16'h0000) rdv = addr[0] ? PART : MAKER;
    else rdv = mem[addr];
  end
  // Released bus shows the inverse of its last value
  assign dq_r = (!rsel && we_n) ? rdv : ~last;
  always @(posedge rsel) last = rdv;
  always @(negedge rsel) if (busy) begin
    if (npoll > 0 && addr != paddr) viol++;
    paddr = addr;
    npoll++;
    tog = ~tog;
  end
  always @(negedge wstb or negedge oe_n) if (!wstb && !oe_n) viol++;
  always @(negedge wstb) if (loading && nload > 0 && addr[16:7] != sec) viol++;

  // Strobes settling from unknown at reset are not writes
  always @(negedge wstb) wseen = 1'b1;

  // Command decode, sector load and program cycle
  always @(posedge wstb iff wseen) begin
    if (dq_oe_n) viol++;
    if (busy) begin
      // Writes ignored during the cycle
    end else if (loading) begin
      if (nload == 0) sec = addr[16:7];
      buf_d[addr[6:0]] = dq_w;
      got[addr[6:0]] = 1'b1;
      nload++;
      if (nload == 128) begin
        loading = 1'b0;
        busy = 1'b1;
        npoll = 0;
        blk = (lock[0] && sec < 10'd64) || (lock[1] && sec >= 10'd960);
        #(PROG_NS);
        for (int i = 0; i < 128; i++)
          if (!blk) mem[{sec, i[6:0]}] = got[i] ? buf_d[i] : 8'hee;
        busy = 1'b0;
      end
    end else begin
      {a2, d2, a1, d1} = {a1, d1, a0, d0};
      a0 = addr[14:0];
      d0 = dq_w;
      if (a2 == flash_host_pkg::CMD_ADDR_A && d2 == flash_host_pkg::CMD_DATA_A &&
          a1 == flash_host_pkg::CMD_ADDR_B && d1 == flash_host_pkg::CMD_DATA_B &&
          a0 == flash_host_pkg::CMD_ADDR_A) begin
        if (lpend && d0 == flash_host_pkg::CMD_LOCK_LO) lock[0] = 1'b1;
        else if (lpend && d0 == flash_host_pkg::CMD_LOCK_HI) lock[1] = 1'b1;
        else if (d0 == flash_host_pkg::CMD_PROG) begin
          loading = 1'b1;
          nload = 0;
          got = '0;
        end
        else if (d0 == flash_host_pkg::CMD_ID_ENTER) idm = 1'b1;
        else if (d0 == flash_host_pkg::CMD_ID_EXIT) idm = 1'b0;
        lpend = (d0 == flash_host_pkg::CMD_LOCK);
      end
    end
  end
endmodule : flash_model

/* File: verif/tb.sv */
// Purpose: Self-checking bench for the sector flash host controller
// Assumes: 250 MHz clock, flash model on the far side
// Notes: Short window and program limits keep the run brief
`timescale 1ns/1ps

module tb;
  localparam logic [7:0] MAKER_ID = 8'h3c;  // Arbitrary value
  localparam logic [7:0] PART_ID = 8'hc3;   // Arbitrary value
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] op_code = 3'h0;
  logic [16:0] op_addr = 17'h00000;
  logic op_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic wr_valid = 1'b0;
  logic op_ready, wr_ready, rd_valid, op_error, ce_n, oe_n, we_n, dq_oe_n, busy;
  logic [7:0] rd_data, dq_out, m_dq, rd_got;
  logic [16:0] f_addr;
  logic [1:0] lock;
  int viol;
  int rd_cnt = 0;
  int errors = 0;
  int num_checks = 0;
  wire [7:0] dq = dq_oe_n ? m_dq : dq_out;  // Level on the data pins

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (rd_valid === 1'b1) begin
    rd_got <= rd_data;
    rd_cnt <= rd_cnt + 1;
  end

  flash_host #(.BLW_CYCLES(200), .SPT_CYCLES(2000), .FIFO_DEPTH(16)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .op_code(op_code), .op_addr(op_addr),
    .op_valid(op_valid), .op_ready(op_ready), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .op_error(op_error),
    .flash_addr(f_addr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq));
  flash_model #(.PROG_NS(4000), .MAKER(MAKER_ID), .PART(PART_ID)) flash (
    .addr(f_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_w(dq_out),
    .dq_oe_n(dq_oe_n), .dq_r(m_dq), .busy(busy), .lock(lock), .viol(viol));

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic hang(input string what);
    errors++;
    $display("unexpected at %0t: %s timed out", $time, what);
    give_verdict();
  endtask : hang

  function automatic logic [7:0] pat(input int k, input int s);
    return 8'(k * 5 + s * 3 + 1);
  endfunction : pat

  task automatic wait_ready();
    int n;
    n = 0;
    while (op_ready !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 60000) hang("op_ready");
    end
  endtask : wait_ready

  task automatic do_op(input logic [2:0] code, input logic [16:0] adr);
    wait_ready();
    op_code = code;
    op_addr = adr;
    op_valid = 1'b1;
    @(negedge sys_clk);
    op_valid = 1'b0;
    wait_ready();
  endtask : do_op

  task automatic rd(input logic [16:0] adr, input logic [7:0] exp);
    int c;
    c = rd_cnt;
    do_op(flash_host_pkg::OP_READ, adr);
    check(17'(rd_cnt - c), 17'd1, "read pulse count");
    check({9'h000, rd_got}, {9'h000, exp}, "read data");
  endtask : rd

  task automatic push(input logic [7:0] b);
    int n;
    n = 0;
    wr_data = b;
    wr_valid = 1'b1;
    @(posedge sys_clk);
    while (wr_ready !== 1'b1) begin
      @(posedge sys_clk);
      n++;
      if (n > 5000) hang("wr_ready");
    end
    @(negedge sys_clk);
  endtask : push

  // Fill the FIFO until it refuses or holds all nb bytes, then program while feeding the rest
  task automatic prog(input int s, input int nb);
    int k;
    k = 0;
    while (wr_ready === 1'b1 && k < nb) begin
      push(pat(k, s));
      k++;
    end
    if (nb == 128) check(17'(k), 17'd16, "fifo depth");
    fork
      do_op(flash_host_pkg::OP_PROG, {s[9:0], 7'h55});
      begin
        for (int i = k; i < nb; i++) push(pat(i, s));
        wr_valid = 1'b0;
      end
    join
    check(17'(op_error), 17'(nb < 128), "error flag after program");
    check(17'(busy), 17'd0, "flash idle at end");
  endtask : prog

  initial begin
    repeat (10) @(negedge sys_clk);
    check({10'h000, ce_n, oe_n, we_n, dq_oe_n, op_ready, wr_ready, rd_valid},
          17'h0007e, "reset levels");
    nrst = 1'b1;
    @(negedge sys_clk);
    rd(17'h00183, 8'h82);
    do_op(flash_host_pkg::OP_ID_ENTER, 17'h00000);
    rd(17'h00000, MAKER_ID);
    rd(17'h00001, PART_ID);
    do_op(flash_host_pkg::OP_ID_EXIT, 17'h00000);
    rd(17'h00000, 8'h00);
    prog(3, 128);
    prog(4, 128);
    rd({10'd3, 7'd0}, pat(0, 3));
    rd({10'd3, 7'd127}, pat(127, 3));
    rd({10'd4, 7'd64}, pat(64, 4));
    do_op(flash_host_pkg::OP_LOCK_LO, 17'h00000);
    check(17'(lock), 17'd1, "lower lockout");
    do_op(flash_host_pkg::OP_LOCK_HI, 17'h00000);
    check(17'(lock), 17'd3, "upper lockout");
    prog(5, 5);
    rd(17'h00000, 8'h00);
    check(17'(op_error), 17'd0, "error cleared by next op");
    check(17'(viol), 17'd0, "host bus faults");
    give_verdict();
  end
endmodule : tb
